// ==== hw/hrs_pkg.sv ====
// Constants, register map and state codes for the home return sequencer.
// Assumes one 40 MHz core clock and a 32-bit Avalon-MM register port.
package hrs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_TIME_NS  = 1000000;

  // Input index map of the filtered pin vector.
  localparam int unsigned NUM_IN    = 18;
  localparam int unsigned IN_AMSEL  = 0;
  localparam int unsigned IN_PT_LO  = 1;
  localparam int unsigned IN_PT_HI  = 8;
  localparam int unsigned IN_BCD_LO = 9;
  localparam int unsigned IN_BCD_HI = 12;
  localparam int unsigned IN_START  = 13;
  localparam int unsigned IN_SRVON  = 14;
  localparam int unsigned IN_DOG    = 15;
  localparam int unsigned IN_EXT_TL = 16;
  localparam int unsigned IN_INT_TL = 17;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SPEED   = 8'h04;
  localparam logic [7:0] REG_CREEP   = 8'h08;
  localparam logic [7:0] REG_SHIFT   = 8'h0C;
  localparam logic [7:0] REG_PRESET  = 8'h10;
  localparam logic [7:0] REG_AFTER   = 8'h14;
  localparam logic [7:0] REG_DWELL   = 8'h18;
  localparam logic [7:0] REG_STOPTL  = 8'h1C;
  localparam logic [7:0] REG_TL2     = 8'h20;
  localparam logic [7:0] REG_FWDTL   = 8'h24;
  localparam logic [7:0] REG_REVTL   = 8'h28;
  localparam logic [7:0] REG_FILTER  = 8'h2C;
  localparam logic [7:0] REG_ACCEL   = 8'h30;
  localparam logic [7:0] REG_STATUS  = 8'h34;
  localparam logic [7:0] REG_POS     = 8'h38;

  // Control register fields.
  localparam int unsigned CTRL_METHOD_LO = 0;
  localparam int unsigned CTRL_METHOD_HI = 3;
  localparam int unsigned CTRL_DIR       = 4;
  localparam int unsigned CTRL_BCD       = 5;

  // Lowest digit of the home method setting.
  localparam logic [3:0] METHOD_STOPPER = 4'h3;
  localparam logic [3:0] METHOD_SRVON   = 4'h4;
  localparam logic [3:0] METHOD_REAR    = 4'h5;

  // Reset values.
  localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
  localparam logic [15:0] RST_TLIM  = 16'hFFFF;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_SEEK   = 6'b000010,
    ST_DWELL  = 6'b000100,
    ST_CREEP  = 6'b001000,
    ST_TRAVEL = 6'b010000,
    ST_DONE   = 6'b100000
  } hrs_state_type;

endpackage : hrs_pkg

// ==== hw/hrs_home_return.sv ====
// Home return sequencer: stopper, servo-on and dog rear-edge methods.
// Assumes motor torque, analog limit and feedback steps come from logic
// on core_clk; all discrete pins are asynchronous and are synchronised.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1 - Manual mode: select high, point inputs low
// RL2 - BCD scheme: four select inputs low
// RL3 - Method digit 3 selects stopper homing
// RL4 - Travel in the configured home direction
// RL5 - Stopper homing runs at home speed
// RL6 - Dwell after contact, then complete
// RL7 - Stopper torque limit applied while homing
// RL8 - Acceleration from point table one
// RL9 - Torque reached flag against active limit
// RL10 - Stopper limit combined with selected limit
// RL11 - Completion loads preset into position
// RL12 - Inputs recognised after filter time
// RL13 - Controller changes selection early enough
// RL14 - Method digit 4: servo-on position home
// RL15 - Dog rear edge plus distances gives home
// RL16 - No index pulse used
// RL17 - Rear edge sampling limits home accuracy
// RL18 - Method digit 5 selects rear-edge homing
// RL19 - Complete low from start until done
// RL20 - Servo-on method completes without motion
module hrs_home_return #(
  parameter int unsigned TICK_CYCLES =
    hrs_pkg::TICK_TIME_NS / hrs_pkg::CLK_PERIOD_NS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        auto_manual_select,
  input  wire logic [7:0]  point_table_select_inputs,
  input  wire logic [3:0]  bcd_select_inputs,
  input  wire logic        home_start,
  input  wire logic        servo_on,
  input  wire logic        proximity_dog,
  input  wire logic        external_torque_select,
  input  wire logic        internal_torque_select,
  input  wire logic [15:0] motor_torque,
  input  wire logic [15:0] analog_torque_limit,
  input  wire logic        feedback_step,
  output logic      [15:0] speed_cmd,
  output logic             direction_out,
  output logic      [15:0] torque_limit_out,
  output logic      [15:0] accel_time_out,
  output logic      [31:0] current_position,
  output logic             home_complete_out,
  output logic             torque_limit_reached_out
);
  import hrs_pkg::*;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  logic                rst_s1_q;
  logic                rst_s2_q;
  logic [NUM_IN-1:0]   raw_in;
  logic [NUM_IN-1:0]   sync1_q;
  logic [NUM_IN-1:0]   sync2_q;
  logic [NUM_IN-1:0]   filt_q;
  logic [31:0]         tick_cnt_q;
  logic                tick_q;
  logic                start_prev_q;
  logic [5:0]          ctrl_q;
  logic [15:0]         speed_q, creep_q, dwell_q, stoptl_q, tl2_q;
  logic [15:0]         fwdtl_q, revtl_q, accel_q;
  logic [7:0]          filter_q;
  logic [31:0]         shift_q, preset_q, after_q;
  logic                error_q;
  logic                waitreq_q;
  logic [31:0]         rdata_q;
  hrs_state_type       state_q;
  logic [31:0]         travel_q;
  logic [15:0]         dwell_cnt_q;
  logic [31:0]         pos_q;
  logic [15:0]         speed_cmd_q, tlim_out_q, accel_out_q;
  logic                dir_out_q, complete_q, tlc_q;

  // Reset release through two flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire rst_int_n = rst_s2_q;

  assign raw_in = {internal_torque_select, external_torque_select,
                   proximity_dog, servo_on, home_start, bcd_select_inputs,
                   point_table_select_inputs, auto_manual_select};

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // Filter time base: one tick per millisecond.
  wire tick_wrap = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tick_cnt_q <= RST_ZERO;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? RST_ZERO : tick_cnt_q + 32'h0000_0001;
      tick_q     <= tick_wrap;
    end
  end

  // A pin change is accepted only once it has stood for the filter time.
  // Each bit keeps its own flop so that no two processes share a variable.
  for (genvar i = 0; i < NUM_IN; i++) begin : g_filt
    logic [7:0] cnt_q;
    logic       bit_q;
    wire        differs = (sync2_q[i] != bit_q);
    wire        expired = (cnt_q >= filter_q);
    assign filt_q[i] = bit_q;
    always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
        cnt_q <= 8'h00;
        bit_q <= 1'b0;
      end else if (!differs) begin
        cnt_q <= 8'h00;
      end else if (expired) begin
        cnt_q <= 8'h00; // RL12
        bit_q <= sync2_q[i]; // RL12
      end else if (tick_q) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // Register slave: one wait cycle, then the access completes.
  wire        wr_fire  = avs_write & ~waitreq_q;
  wire        rd_take  = (avs_read | avs_write) & waitreq_q;
  wire [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] status_w = {24'h00_0000, error_q, tlc_q, complete_q,
                          (state_q != ST_IDLE), 4'h0};
  logic [31:0] cur_word;

  always_comb begin
    case (avs_address)
      REG_CTRL:   cur_word = {26'h000_0000, ctrl_q};
      REG_SPEED:  cur_word = {16'h0000, speed_q};
      REG_CREEP:  cur_word = {16'h0000, creep_q};
      REG_SHIFT:  cur_word = shift_q;
      REG_PRESET: cur_word = preset_q;
      REG_AFTER:  cur_word = after_q;
      REG_DWELL:  cur_word = {16'h0000, dwell_q};
      REG_STOPTL: cur_word = {16'h0000, stoptl_q};
      REG_TL2:    cur_word = {16'h0000, tl2_q};
      REG_FWDTL:  cur_word = {16'h0000, fwdtl_q};
      REG_REVTL:  cur_word = {16'h0000, revtl_q};
      REG_FILTER: cur_word = {24'h00_0000, filter_q};
      REG_ACCEL:  cur_word = {16'h0000, accel_q};
      REG_STATUS: cur_word = status_w;
      REG_POS:    cur_word = pos_q;
      default:    cur_word = RST_ZERO;
    endcase
  end

  wire [31:0] wmerge = (cur_word & ~be_mask) | (avs_writedata & be_mask);

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      waitreq_q <= 1'b1;
      rdata_q   <= RST_ZERO;
    end else begin
      waitreq_q <= ~rd_take;
      if (rd_take) begin
        rdata_q <= avs_read ? cur_word : RST_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ctrl_q   <= RST_ZERO[5:0];
      speed_q  <= RST_ZERO[15:0];
      creep_q  <= RST_ZERO[15:0];
      shift_q  <= RST_ZERO;
      preset_q <= RST_ZERO;
      after_q  <= RST_ZERO;
      dwell_q  <= RST_ZERO[15:0];
      stoptl_q <= RST_TLIM;
      tl2_q    <= RST_TLIM;
      fwdtl_q  <= RST_TLIM;
      revtl_q  <= RST_TLIM;
      filter_q <= RST_ZERO[7:0];
      accel_q  <= RST_ZERO[15:0];
    end else if (wr_fire) begin
      case (avs_address)
        REG_CTRL:   ctrl_q   <= wmerge[5:0];
        REG_SPEED:  speed_q  <= wmerge[15:0];
        REG_CREEP:  creep_q  <= wmerge[15:0];
        REG_SHIFT:  shift_q  <= wmerge;
        REG_PRESET: preset_q <= wmerge;
        REG_AFTER:  after_q  <= wmerge;
        REG_DWELL:  dwell_q  <= wmerge[15:0];
        REG_STOPTL: stoptl_q <= wmerge[15:0];
        REG_TL2:    tl2_q    <= wmerge[15:0];
        REG_FWDTL:  fwdtl_q  <= wmerge[15:0];
        REG_REVTL:  revtl_q  <= wmerge[15:0];
        REG_FILTER: filter_q <= wmerge[7:0];
        REG_ACCEL:  accel_q  <= wmerge[15:0];
        default:    ;
      endcase
    end
  end

  // Mode and request decode.
  wire [3:0] method   = ctrl_q[CTRL_METHOD_HI:CTRL_METHOD_LO];
  wire       home_dir = ctrl_q[CTRL_DIR];
  wire       sel_clear = ctrl_q[CTRL_BCD] ?
                         (filt_q[IN_BCD_HI:IN_BCD_LO] == 4'h0) : // RL2
                         (filt_q[IN_PT_HI:IN_PT_LO] == 8'h00);   // RL1
  wire       manual_home = filt_q[IN_AMSEL] & sel_clear; // RL1
  wire       start_rise  = filt_q[IN_START] & ~start_prev_q;
  wire       dog         = filt_q[IN_DOG]; // RL17
  wire       is_stopper  = (method == METHOD_STOPPER); // RL3
  wire       is_srvon    = (method == METHOD_SRVON);   // RL14
  wire       is_rear     = (method == METHOD_REAR);    // RL18
  wire       method_ok   = is_stopper | is_srvon | is_rear;
  wire       go          = manual_home & start_rise;

  // Active torque limit selection.
  wire        int_sel  = filt_q[IN_INT_TL];
  wire        ext_sel  = filt_q[IN_EXT_TL];
  wire        homing_stop = is_stopper & (state_q == ST_SEEK |
                                          state_q == ST_DWELL);
  wire [15:0] base_lim = homing_stop ? stoptl_q : // RL7
                         (home_dir ? revtl_q : fwdtl_q);
  wire [15:0] sel_lim  = ext_sel ? analog_torque_limit : tl2_q; // RL10
  wire        use_sel  = ext_sel | int_sel; // RL10
  wire [15:0] act_lim  = (use_sel && sel_lim < base_lim) ?
                         sel_lim : base_lim; // RL10
  wire        tlc_now  = (motor_torque >= act_lim); // RL9
  wire        dwell_end = tick_q && (dwell_cnt_q >= dwell_q);
  wire        travel_end = (travel_q == RST_ZERO);

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      start_prev_q <= 1'b0;
      tlc_q        <= 1'b0;
      tlim_out_q   <= RST_TLIM;
    end else begin
      start_prev_q <= filt_q[IN_START];
      tlc_q        <= tlc_now; // RL9
      tlim_out_q   <= act_lim; // RL7
    end
  end

  // Sequencer.  The dog rear edge is seen only after sync and filter, so
  // the home point moves with the creep speed; no index pulse is used.
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_q     <= ST_IDLE;
      travel_q    <= RST_ZERO;
      dwell_cnt_q <= RST_ZERO[15:0];
      speed_cmd_q <= RST_ZERO[15:0];
      dir_out_q   <= 1'b0;
      accel_out_q <= RST_ZERO[15:0];
      complete_q  <= 1'b0;
      error_q     <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE, ST_DONE: begin
          if (go) begin
            error_q    <= ~method_ok;
            if (method_ok) begin
              complete_q  <= 1'b0; // RL19
              state_q     <= ST_SEEK;
              dir_out_q   <= home_dir; // RL4
              accel_out_q <= accel_q; // RL8
              speed_cmd_q <= is_srvon ? RST_ZERO[15:0] : speed_q; // RL5
            end
          end
        end
        ST_SEEK: begin
          dwell_cnt_q <= RST_ZERO[15:0];
          if (is_srvon && filt_q[IN_SRVON]) begin
            state_q <= ST_DONE; // RL20
          end else if (is_stopper && tlc_now) begin
            state_q <= ST_DWELL; // RL6
          end else if (is_rear && dog) begin
            state_q     <= ST_CREEP; // RL15
            speed_cmd_q <= creep_q; // RL15
          end
        end
        ST_DWELL: begin
          if (dwell_end) begin
            state_q     <= ST_DONE; // RL6
            speed_cmd_q <= RST_ZERO[15:0];
          end else if (tick_q) begin
            dwell_cnt_q <= dwell_cnt_q + 16'h0001;
          end
        end
        ST_CREEP: begin
          if (!dog) begin
            state_q  <= ST_TRAVEL; // RL15
            travel_q <= after_q + shift_q; // RL15
          end
        end
        ST_TRAVEL: begin
          if (travel_end) begin
            state_q     <= ST_DONE; // RL15
            speed_cmd_q <= RST_ZERO[15:0];
          end else if (feedback_step) begin
            travel_q <= travel_q - 32'h0000_0001; // RL16
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (state_q != ST_IDLE && state_q != ST_DONE && !manual_home) begin
        state_q     <= ST_IDLE;
        speed_cmd_q <= RST_ZERO[15:0];
      end
      if (state_q == ST_DONE && !go) begin
        complete_q <= 1'b1; // RL6
      end
    end
  end

  // Current position: follows feedback, loaded with the preset on done.
  wire entering_done = (state_q == ST_DONE) && !complete_q;

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pos_q <= RST_ZERO;
    end else if (entering_done) begin
      pos_q <= preset_q; // RL11
    end else if (feedback_step) begin
      pos_q <= dir_out_q ? pos_q - 32'h0000_0001 : pos_q + 32'h0000_0001;
    end
  end

  assign avs_readdata             = rdata_q;
  assign avs_waitrequest          = waitreq_q;
  assign speed_cmd                = speed_cmd_q;
  assign direction_out            = dir_out_q;
  assign torque_limit_out         = tlim_out_q;
  assign accel_time_out           = accel_out_q;
  assign current_position         = pos_q;
  assign home_complete_out        = complete_q;
  assign torque_limit_reached_out = tlc_q;

endmodule : hrs_home_return
`default_nettype wire

// ==== tb/hrs_home_return_props.sv ====
// Concurrent checks on the home return sequencer's ports.
// Assumes one core clock and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hrs_home_return_props #(
  parameter int unsigned TICK_CYCLES = 40000
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] motor_torque,
  input wire logic        feedback_step,
  input wire logic [15:0] speed_cmd,
  input wire logic        direction_out,
  input wire logic [15:0] torque_limit_out,
  input wire logic [15:0] accel_time_out,
  input wire logic [31:0] current_position,
  input wire logic        home_complete_out,
  input wire logic        torque_limit_reached_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wait_once_a: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one");
  wait_back_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  tlc_follow_a: assert property (
    torque_limit_reached_out == ($past(motor_torque) >= torque_limit_out))
    else $error("torque reached flag wrong");
  dir_hold_a: assert property (
    speed_cmd != 16'h0 && $past(speed_cmd) != 16'h0 |->
    $stable(direction_out)) else $error("direction moved in motion");
  accel_hold_a: assert property (
    speed_cmd != 16'h0 && $past(speed_cmd) != 16'h0 |->
    $stable(accel_time_out)) else $error("accel moved in motion");
  done_still_a: assert property (
    home_complete_out |-> speed_cmd == 16'h0)
    else $error("motion while complete");
  done_rise_a: assert property ($rose(home_complete_out) |->
    $past(speed_cmd) == 16'h0) else $error("complete before stop");
  pos_hold_a: assert property (
    home_complete_out && $past(home_complete_out) && !$past(feedback_step)
    |-> $stable(current_position)) else $error("position drifted");

  cover property ($rose(home_complete_out));
  cover property ($rose(torque_limit_reached_out));
  cover property (avs_read && !avs_waitrequest);
endmodule // hrs_home_return_props

bind hrs_home_return hrs_home_return_props #(.TICK_CYCLES(TICK_CYCLES))
  i_props (.core_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .motor_torque, .feedback_step, .speed_cmd, .direction_out,
  .torque_limit_out, .accel_time_out, .current_position,
  .home_complete_out, .torque_limit_reached_out);
`default_nettype wire

// ==== tb/hrs_axis_model.sv ====
// Axis model: turns speed commands into feedback pulses and torque.
// Assumes the testbench says when the part presses on the stopper.
`timescale 1ns/1ps
`default_nettype none
module hrs_axis_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] speed_cmd,
  input  wire logic        wall,
  output logic             feedback_step,
  output logic      [15:0] motor_torque
);
  logic      tog_q;
  wire logic moving = speed_cmd != 16'h0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) tog_q <= 1'b0;
    else tog_q <= ~tog_q;
  end
  // Pressing on the stopper stalls the axis and drives torque past limits.
  assign feedback_step = moving && !wall && tog_q;
  assign motor_torque  = (moving && wall) ? 16'h0FFF : 16'h0010;
endmodule // hrs_axis_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the home return sequencer.
// Assumes the axis model stands at the motor side of the block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  mismatches++; $display("wrong value at %0t: %0h vs %0h", $time, a, b); \
  end end
`define WT(c) for (n = 0; !(c) && n < 3000; n++) @(posedge core_clk); \
  if (n >= 3000) begin mismatches++; complete_run(); end
module tb;
  import hrs_pkg::*;
  localparam int TK = 4;
  logic        core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        auto_manual_select, home_start, servo_on, proximity_dog;
  logic        external_torque_select, internal_torque_select, wall;
  logic        feedback_step, direction_out, done_q;
  logic        home_complete_out, torque_limit_reached_out;
  logic [7:0]  avs_address, point_table_select_inputs;
  logic [3:0]  avs_byteenable, bcd_select_inputs;
  logic [15:0] motor_torque, analog_torque_limit, speed_cmd, spd, crp;
  logic [15:0] torque_limit_out, accel_time_out, acc;
  logic [31:0] avs_writedata, avs_readdata, current_position, pre, e;
  logic [31:0] rq[$], hq[$];
  logic [7:0]  ra[5] = '{REG_SPEED, REG_STOPTL, REG_FWDTL, REG_POS, 8'h3C};
  logic [31:0] rv[5] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0};
  logic [1:0]  sel[4] = '{2'b01, 2'b10, 2'b11, 2'b00};
  logic [15:0] an[4] = '{16'h0100, 16'h0100, 16'h0800, 16'h0100};
  logic [15:0] lim[4] = '{16'h0200, 16'h0100, 16'h0400, 16'h0400};
  int          n, k, mismatches, cmp_count;
  integer      seed = 32'hbdbd63ef;

  hrs_home_return #(.TICK_CYCLES(TK)) i_hrs_home_return (.core_clk,
    .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .auto_manual_select,
    .point_table_select_inputs, .bcd_select_inputs, .home_start,
    .servo_on, .proximity_dog, .external_torque_select,
    .internal_torque_select, .motor_torque, .analog_torque_limit,
    .feedback_step, .speed_cmd, .direction_out, .torque_limit_out,
    .accel_time_out, .current_position, .home_complete_out,
    .torque_limit_reached_out);
  hrs_axis_model i_hrs_axis_model (.core_clk, .rst_n, .speed_cmd, .wall,
    .feedback_step, .motor_torque);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    `WT(avs_waitrequest === 1'b0 && n > 0)
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic start();
    home_start <= 1'b1;
    repeat (6) @(posedge core_clk);
    home_start <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  // Reads and completions are checked against the oldest noted value.
  always @(posedge core_clk) begin
    if (avs_read && !avs_waitrequest) begin
      e = rq.pop_front();
      `CHK(avs_readdata, e)
    end
    if (home_complete_out && !done_q) begin
      e = hq.pop_front();
      `CHK(current_position, e)
    end
    done_q = home_complete_out;
  end

  initial begin
    {rst_n, avs_read, avs_write, home_start, servo_on, wall} = 6'h0;
    {auto_manual_select, proximity_dog, done_q} = 3'h0;
    {external_torque_select, internal_torque_select} = 2'h0;
    {avs_address, point_table_select_inputs, avs_writedata} = 48'h0;
    avs_byteenable = 4'hF;
    bcd_select_inputs = 4'h0;
    analog_torque_limit = 16'h0100;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    foreach (ra[i]) begin
      rq.push_back(rv[i]);
      bus(1'b0, ra[i], 32'h0);
    end
    pre = $random(seed);
    spd = 16'($random(seed)) & 16'h7FFF | 16'h0001;
    acc = 16'($random(seed));
    rq.push_back(pre);
    bus(1'b1, REG_PRESET, pre);
    bus(1'b0, REG_PRESET, 32'h0);
    bus(1'b1, REG_SPEED, {16'h0, spd});
    bus(1'b1, REG_ACCEL, {16'h0, acc});
    bus(1'b1, REG_DWELL, 32'h3);
    bus(1'b1, REG_STOPTL, 32'h0400);
    bus(1'b1, REG_TL2, 32'h0200);
    bus(1'b1, REG_CTRL, 32'h3);
    auto_manual_select <= 1'b1;
    point_table_select_inputs <= 8'h01;
    start();
    `CHK(speed_cmd, 16'h0)
    point_table_select_inputs <= 8'h00;
    hq.push_back(pre);
    start();
    `WT(speed_cmd != 16'h0)
    `CHK(speed_cmd, spd)
    `CHK(accel_time_out, acc)
    `CHK(torque_limit_out, 16'h0400)
    for (int i = 0; i < 4; i++) begin
      {external_torque_select, internal_torque_select} <= sel[i];
      analog_torque_limit <= an[i];
      repeat (6) @(posedge core_clk);
      `CHK(torque_limit_out, lim[i])
    end
    wall <= 1'b1;
    `WT(home_complete_out)
    `CHK(n >= 3 * TK && n <= 6 * TK + 8, 1'b1)
    wall <= 1'b0;
    pre = $random(seed);
    bus(1'b1, REG_PRESET, pre);
    bus(1'b1, REG_CTRL, 32'h24);
    point_table_select_inputs <= 8'h01;
    hq.push_back(pre);
    start();
    repeat (20) @(posedge core_clk);
    `CHK(home_complete_out, 1'b0)
    `CHK(speed_cmd, 16'h0)
    servo_on <= 1'b1;
    `WT(home_complete_out)
    pre = $random(seed);
    crp = 16'($random(seed)) & 16'h00FF | 16'h0001;
    bus(1'b1, REG_PRESET, pre);
    bus(1'b1, REG_CREEP, {16'h0, crp});
    bus(1'b1, REG_AFTER, 32'h3);
    bus(1'b1, REG_SHIFT, 32'h2);
    point_table_select_inputs <= 8'h00;
    bus(1'b1, REG_CTRL, 32'h15);
    hq.push_back(pre);
    start();
    `WT(speed_cmd != 16'h0)
    `CHK(direction_out, 1'b1)
    `CHK(speed_cmd, spd)
    proximity_dog <= 1'b1;
    `WT(speed_cmd === crp)
    proximity_dog <= 1'b0;
    for (n = 0, k = 0; !home_complete_out && n < 3000; n++) begin
      @(posedge core_clk);
      k += int'(feedback_step);
    end
    if (n >= 3000) begin
      mismatches++;
      complete_run();
    end
    `CHK(k >= 5 && k <= 9, 1'b1)
    bus(1'b1, REG_CTRL, 32'h1);
    start();
    `CHK(speed_cmd, 16'h0)
    `CHK(home_complete_out, 1'b1)
    bus(1'b1, REG_FILTER, 32'h3);
    bus(1'b1, REG_CTRL, 32'h3);
    start();
    `CHK(home_complete_out, 1'b1)
    `CHK(speed_cmd, 16'h0)
    complete_run();
  end
endmodule // tb
`default_nettype wire
